// [hw/phy_regs_pkg.sv]
package phy_regs_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [4:0] REG_CTRL_ADDR   = 5'h00;
  localparam logic [4:0] REG_STATUS_ADDR = 5'h01;

  // ---------------------------------------------------------------
  // Control field positions and reset values
  // ---------------------------------------------------------------
  localparam int CTRL_SPEED_LO_BIT   = 13;
  localparam int CTRL_AN_EN_BIT      = 12;
  localparam int CTRL_ISOLATE_BIT    = 10;
  localparam int CTRL_AN_RESTART_BIT = 9;
  localparam int CTRL_DUPLEX_BIT     = 8;
  localparam int CTRL_COL_TEST_BIT   = 7;
  localparam int CTRL_SPEED_HI_BIT   = 6;
  localparam logic SPEED_HI_RST      = 1'b1;
  localparam logic CTRL_BIT_RST      = 1'b0;

  // ---------------------------------------------------------------
  // Status field positions and constant bits
  // ---------------------------------------------------------------
  localparam int STAT_AN_DONE_BIT = 5;
  localparam int STAT_RFAULT_BIT  = 4;
  localparam int STAT_LINK_BIT    = 2;
  localparam logic [15:0] STATUS_FIXED = 16'h7948;

  // ---------------------------------------------------------------
  // Management frame fields
  // ---------------------------------------------------------------
  localparam logic [1:0] OP_READ      = 2'b10;
  localparam logic [1:0] OP_WRITE     = 2'b01;
  localparam logic [5:0] PREAMBLE_LEN = 6'd32;
  localparam logic [3:0] HDR_LAST     = 4'd11;
  localparam logic [3:0] DATA_LAST    = 4'd15;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS          = 8;
  localparam int BIT_NS          = 10;
  localparam int COL_ON_BITS     = 512;
  localparam int COL_OFF_BITS    = 4;
  localparam int COL_ON_MAX_CYC  = (COL_ON_BITS * BIT_NS) / CLK_NS;
  localparam int COL_OFF_MAX_CYC = (COL_OFF_BITS * BIT_NS) / CLK_NS;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  // One-hot speed: [2]=1000, [1]=100, [0]=10; reserved code gives none
  function automatic logic [2:0] speed_decode(input logic [1:0] code);
    case (code)
      2'b10:   speed_decode = 3'h4;
      2'b01:   speed_decode = 3'h2;
      2'b00:   speed_decode = 3'h1;
      default: speed_decode = 3'h0;
    endcase
  endfunction

endpackage

// [hw/mgmt_serial_slave.sv]
`timescale 1ns/100ps
module mgmt_serial_slave
  import phy_regs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  input  wire logic [4:0]  phy_addr,
  input  wire logic [15:0] rd_data,
  output logic             mdio_out,
  output logic             mdio_oe,
  output logic             rd_req,
  output logic             wr_stb,
  output logic [4:0]       reg_addr,
  output logic [15:0]      wr_data
);

  typedef enum logic [5:0] {
    S_IDLE = 6'b000001, S_ST = 6'b000010, S_HDR = 6'b000100,
    S_TA   = 6'b001000, S_WDAT = 6'b010000, S_RDAT = 6'b100000
  } mstate_t;

  mstate_t     state_r;
  logic [2:0]  mdc_r;
  logic [1:0]  mdio_r;
  logic [3:0]  cnt_r;
  logic [15:0] sh_r;
  logic [5:0]  ones_r;
  logic        need_pre_r;
  logic        is_read_r;
  logic        mine_r;

  wire        edge_w = mdc_r[1] & ~mdc_r[2];
  wire        bit_w  = mdio_r[1];
  wire [11:0] hdr_w  = {sh_r[10:0], bit_w};
  wire        op_ok  = (hdr_w[11:10] == OP_READ) || (hdr_w[11:10] == OP_WRITE);
  wire        pre_ok = !need_pre_r || (ones_r >= PREAMBLE_LEN);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mdc_r  <= 3'h0;
      mdio_r <= 2'h0;
    end else begin
      mdc_r  <= {mdc_r[1:0], mdc};
      mdio_r <= {mdio_r[0], mdio_in};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r    <= S_IDLE;
      cnt_r      <= 4'h0;
      sh_r       <= 16'h0000;
      ones_r     <= 6'h00;
      need_pre_r <= 1'b1;
      is_read_r  <= 1'b0;
      mine_r     <= 1'b0;
      mdio_out   <= 1'b0;
      mdio_oe    <= 1'b0;
      rd_req     <= 1'b0;
      wr_stb     <= 1'b0;
      reg_addr   <= 5'h00;
      wr_data    <= 16'h0000;
    end else begin
      rd_req <= 1'b0;
      wr_stb <= 1'b0;
      if (rd_req) begin
        sh_r <= rd_data;
      end else if (edge_w) begin
        case (state_r)
          S_IDLE: begin
            ones_r <= bit_w ? ((ones_r == PREAMBLE_LEN) ? ones_r : ones_r + 6'h01) : 6'h00;
            if (!bit_w && pre_ok) begin
              state_r <= S_ST;
            end
          end
          S_ST: begin
            ones_r <= 6'h00;
            if (bit_w) begin
              need_pre_r <= 1'b0;
              cnt_r      <= 4'h0;
              state_r    <= S_HDR;
            end else begin
              need_pre_r <= 1'b1;
              state_r    <= S_IDLE;
            end
          end
          S_HDR: begin
            sh_r  <= {sh_r[14:0], bit_w};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == HDR_LAST) begin
              cnt_r <= 4'h0;
              if (op_ok) begin
                is_read_r <= (hdr_w[11:10] == OP_READ);
                mine_r    <= (hdr_w[9:5] == phy_addr);
                reg_addr  <= hdr_w[4:0];
                state_r   <= S_TA;
              end else begin
                need_pre_r <= 1'b1;
                state_r    <= S_IDLE;
              end
            end
          end
          S_TA: begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'h0) begin
              if (is_read_r) begin
                mdio_oe  <= mine_r;
                mdio_out <= 1'b0;
                rd_req   <= mine_r;
              end else if (!bit_w) begin
                need_pre_r <= 1'b1;
                state_r    <= S_IDLE;
              end
            end else begin
              cnt_r <= 4'h0;
              if (is_read_r) begin
                mdio_out <= sh_r[15];
                sh_r     <= {sh_r[14:0], 1'b0};
                state_r  <= S_RDAT;
              end else if (bit_w) begin
                need_pre_r <= 1'b1;
                state_r    <= S_IDLE;
              end else begin
                state_r <= S_WDAT;
              end
            end
          end
          S_RDAT: begin
            cnt_r    <= cnt_r + 4'h1;
            mdio_out <= sh_r[15];
            sh_r     <= {sh_r[14:0], 1'b0};
            if (cnt_r == DATA_LAST) begin
              mdio_oe <= 1'b0;
              state_r <= S_IDLE;
            end
          end
          S_WDAT: begin
            cnt_r <= cnt_r + 4'h1;
            sh_r  <= {sh_r[14:0], bit_w};
            if (cnt_r == DATA_LAST) begin
              wr_stb  <= mine_r;
              wr_data <= {sh_r[14:0], bit_w};
              state_r <= S_IDLE;
            end
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end

endmodule

// [hw/col_test_gen.sv]
`timescale 1ns/100ps
module col_test_gen
  import phy_regs_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic tx_en,
  input  wire logic col_test,
  input  wire logic isolate,
  output logic      col
);

  localparam int ON_LIM  = COL_ON_MAX_CYC;
  localparam int OFF_LIM = COL_OFF_MAX_CYC;

  logic tx_s1_r;
  logic tx_s2_r;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_s1_r <= 1'b0;
      tx_s2_r <= 1'b0;
      col     <= 1'b0;
    end else begin
      tx_s1_r <= tx_en;
      tx_s2_r <= tx_s1_r;
      col     <= tx_s2_r & col_test & ~isolate;
    end
  end

  property p_col_on;
    @(posedge ref_clk) disable iff (!resetn)
      $rose(tx_s2_r) && col_test && !isolate ##1 (col_test && !isolate)
      |-> ##[0:ON_LIM] col;
  endproperty
  a_col_on: assert property (p_col_on) else $error("col late after tx_en");

  property p_col_off;
    @(posedge ref_clk) disable iff (!resetn)
      $fell(tx_s2_r) |-> ##[1:OFF_LIM] !col;
  endproperty
  a_col_off: assert property (p_col_off) else $error("col held after tx_en");

endmodule

// [hw/phy_basic_regs.sv]
`timescale 1ns/100ps
module phy_basic_regs
  import phy_regs_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe,
  input  wire logic [4:0] phy_addr_strap,
  input  wire logic       an_en_strap,
  input  wire logic       duplex_strap,
  input  wire logic       tx_en,
  output logic            col,
  input  wire logic       an_started,
  input  wire logic       an_complete,
  input  wire logic [1:0] an_speed,
  input  wire logic       an_full_duplex,
  input  wire logic       link_ok,
  input  wire logic       far_end_fault,
  input  wire logic       partner_rfault,
  output logic            mac_isolate,
  output logic            an_enable,
  output logic            an_restart_req,
  output logic [2:0]      speed_sel,
  output logic            full_duplex
);

  // ---------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------
  logic [6:0] strap_s1_r;
  logic [6:0] strap_s2_r;
  logic [1:0] cfg_cnt_r;
  logic       cfg_loaded_r;
  logic [4:0] phy_addr_r;

  wire load_w = (cfg_cnt_r == 2'h0) && !cfg_loaded_r;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strap_s1_r <= 7'h00;
      strap_s2_r <= 7'h00;
    end else begin
      strap_s1_r <= {phy_addr_strap, an_en_strap, duplex_strap};
      strap_s2_r <= strap_s1_r;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_cnt_r    <= STRAP_WAIT;
      cfg_loaded_r <= 1'b0;
      phy_addr_r   <= 5'h00;
    end else begin
      if (cfg_cnt_r != 2'h0) begin
        cfg_cnt_r <= cfg_cnt_r - 2'h1;
      end
      if (load_w) begin
        cfg_loaded_r <= 1'b1;
        phy_addr_r   <= strap_s2_r[6:2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Management access
  // ---------------------------------------------------------------
  logic        rd_req;
  logic        wr_stb;
  logic [4:0]  reg_addr;
  logic [15:0] wr_data;
  logic [15:0] rd_data;

  mgmt_serial_slave u_mgmt (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .mdc      (mdc),
    .mdio_in  (mdio_in),
    .phy_addr (phy_addr_r),
    .rd_data  (rd_data),
    .mdio_out (mdio_out),
    .mdio_oe  (mdio_oe),
    .rd_req   (rd_req),
    .wr_stb   (wr_stb),
    .reg_addr (reg_addr),
    .wr_data  (wr_data)
  );

  wire wr_ctrl     = wr_stb && (reg_addr == REG_CTRL_ADDR) && cfg_loaded_r;
  wire stat_rd_stb = rd_req && (reg_addr == REG_STATUS_ADDR);

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  logic speed_lo_r;
  logic an_en_r;
  logic isolate_r;
  logic restart_r;
  logic duplex_r;
  logic col_test_r;
  logic speed_hi_r;

  wire an_en_nxt   = wr_ctrl ? wr_data[CTRL_AN_EN_BIT] : an_en_r;
  wire restart_set = wr_ctrl && wr_data[CTRL_AN_RESTART_BIT] && wr_data[CTRL_AN_EN_BIT];
  wire restart_nxt = restart_set || (restart_r && !an_started && an_en_nxt);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      speed_lo_r <= CTRL_BIT_RST;
      an_en_r    <= CTRL_BIT_RST;
      isolate_r  <= CTRL_BIT_RST;
      restart_r  <= CTRL_BIT_RST;
      duplex_r   <= CTRL_BIT_RST;
      col_test_r <= CTRL_BIT_RST;
      speed_hi_r <= SPEED_HI_RST;
    end else if (load_w) begin
      an_en_r  <= strap_s2_r[1];
      duplex_r <= strap_s2_r[0];
    end else begin
      restart_r <= restart_nxt;
      if (wr_ctrl) begin
        speed_lo_r <= wr_data[CTRL_SPEED_LO_BIT];
        an_en_r    <= wr_data[CTRL_AN_EN_BIT];
        isolate_r  <= wr_data[CTRL_ISOLATE_BIT];
        duplex_r   <= wr_data[CTRL_DUPLEX_BIT];
        col_test_r <= wr_data[CTRL_COL_TEST_BIT];
        speed_hi_r <= wr_data[CTRL_SPEED_HI_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Status latches
  // ---------------------------------------------------------------
  logic rfault_r;
  logic link_r;

  wire fault_w = far_end_fault || partner_rfault;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rfault_r <= 1'b0;
      link_r   <= 1'b0;
    end else begin
      rfault_r <= fault_w || (rfault_r && !stat_rd_stb);
      link_r   <= link_ok && (link_r || stat_rd_stb);
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  wire [15:0] ctrl_rd = {2'b00, speed_lo_r, an_en_r, 1'b0, isolate_r, restart_r,
                         duplex_r, col_test_r, speed_hi_r, 6'h00};
  wire [15:0] stat_rd = STATUS_FIXED
                      | (16'(an_complete) << STAT_AN_DONE_BIT)
                      | (16'(rfault_r) << STAT_RFAULT_BIT)
                      | (16'(link_r) << STAT_LINK_BIT);

  assign rd_data = (reg_addr == REG_CTRL_ADDR)   ? ctrl_rd :
                   (reg_addr == REG_STATUS_ADDR) ? stat_rd : 16'h0000;

  // ---------------------------------------------------------------
  // Effective mode outputs
  // ---------------------------------------------------------------
  wire [2:0] speed_nxt  = an_en_r ? speed_decode(an_speed)
                                  : speed_decode({speed_hi_r, speed_lo_r});
  wire       duplex_nxt = an_en_r ? an_full_duplex : duplex_r;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mac_isolate    <= 1'b0;
      an_enable      <= 1'b0;
      an_restart_req <= 1'b0;
      speed_sel      <= 3'h0;
      full_duplex    <= 1'b0;
    end else begin
      mac_isolate    <= isolate_r;
      an_enable      <= an_en_r;
      an_restart_req <= restart_r;
      speed_sel      <= speed_nxt;
      full_duplex    <= duplex_nxt;
    end
  end

  col_test_gen u_col (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .tx_en    (tx_en),
    .col_test (col_test_r),
    .isolate  (isolate_r),
    .col      (col)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_isolate;
    @(posedge ref_clk) disable iff (!resetn)
      wr_ctrl |-> ##2 (mac_isolate == $past(wr_data[CTRL_ISOLATE_BIT], 2));
  endproperty
  a_isolate: assert property (p_isolate) else $error("isolate not applied");

  property p_restart_hold;
    @(posedge ref_clk) disable iff (!resetn)
      restart_r && !an_started && !wr_ctrl |=> restart_r;
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("restart lost");

  property p_restart_clear;
    @(posedge ref_clk) disable iff (!resetn)
      an_started && !restart_set |=> !restart_r ##1 !an_restart_req;
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("restart stuck");

  property p_restart_ignored;
    @(posedge ref_clk) disable iff (!resetn)
      wr_ctrl && !wr_data[CTRL_AN_EN_BIT] |=> !restart_r;
  endproperty
  a_restart_ignored: assert property (p_restart_ignored) else $error("restart taken");

  property p_restart_zero;
    @(posedge ref_clk) disable iff (!resetn)
      wr_ctrl && wr_data[CTRL_AN_EN_BIT] && restart_r && !an_started |=> restart_r;
  endproperty
  a_restart_zero: assert property (p_restart_zero) else $error("restart cleared");

  property p_forced_duplex;
    @(posedge ref_clk) disable iff (!resetn)
      !an_en_r |=> (full_duplex == $past(duplex_r));
  endproperty
  a_forced_duplex: assert property (p_forced_duplex) else $error("duplex wrong");

  property p_speed_reset;
    @(posedge ref_clk) disable iff (!resetn)
      !cfg_loaded_r |-> speed_hi_r && !speed_lo_r;
  endproperty
  a_speed_reset: assert property (p_speed_reset) else $error("speed reset wrong");

  property p_speed_1000;
    @(posedge ref_clk) disable iff (!resetn)
      !an_en_r && speed_hi_r && !speed_lo_r |=> speed_sel == 3'h4;
  endproperty
  a_speed_1000: assert property (p_speed_1000) else $error("speed decode wrong");

  property p_an_follow;
    @(posedge ref_clk) disable iff (!resetn)
      an_en_r |=> full_duplex == $past(an_full_duplex);
  endproperty
  a_an_follow: assert property (p_an_follow) else $error("forced bits used");

  property p_rfault_latch;
    @(posedge ref_clk) disable iff (!resetn)
      fault_w ##1 !stat_rd_stb [*2] |=> rfault_r;
  endproperty
  a_rfault_latch: assert property (p_rfault_latch) else $error("fault not held");

  property p_link_low;
    @(posedge ref_clk) disable iff (!resetn)
      !link_ok |=> !link_r;
  endproperty
  a_link_low: assert property (p_link_low) else $error("link not dropped");

  property p_link_rise;
    @(posedge ref_clk) disable iff (!resetn)
      $rose(link_r) |-> $past(stat_rd_stb);
  endproperty
  a_link_rise: assert property (p_link_rise) else $error("link rose unread");

  property p_snapshot;
    @(posedge ref_clk) disable iff (!resetn)
      stat_rd_stb && rfault_r && !fault_w |-> rd_data[STAT_RFAULT_BIT] ##1 !rfault_r;
  endproperty
  a_snapshot: assert property (p_snapshot) else $error("read lost fault");

endmodule

// [dv/mgmt_ctrl_model.sv]
`timescale 1ns/100ps
module mgmt_ctrl_model
  import phy_regs_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   mdio_wire,
  output logic        mdc,
  output logic        mdio_drv,
  output logic        mdio_drv_en,
  output logic        rd_done,
  output logic [15:0] rd_word
);
  initial begin
    mdc         = 1'b0;
    mdio_drv    = 1'b1;
    mdio_drv_en = 1'b0;
    rd_done     = 1'b0;
    rd_word     = 16'h0000;
  end

  // One clock period, low half first, capture before rise
  task automatic pulse(input logic cap);
    repeat (4) @(posedge ref_clk);
    #1;
    if (cap) rd_word = {rd_word[14:0], mdio_wire};
    mdc = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 mdc = 1'b0;
  endtask

  task automatic frame(input logic pre, input logic [1:0] op, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd);
    logic [31:0] bits;
    bits = {2'b01, op, pa, ra, 2'b10, wd};
    mdio_drv_en = 1'b1;
    repeat (pre ? 32 : 0) begin
      mdio_drv = 1'b1;
      pulse(1'b0);
    end
    for (int i = 31; i >= 0; i--) begin
      if (i == 17 && op == OP_READ) break;
      mdio_drv = bits[i];
      pulse(1'b0);
    end
    mdio_drv_en = 1'b0;
    if (op == OP_READ) begin
      for (int i = 0; i < 18; i++) pulse(i >= 2);
      rd_done = 1'b1;
      @(posedge ref_clk);
      #1 rd_done = 1'b0;
    end
    repeat (8) @(posedge ref_clk);
    #1;
  endtask
endmodule

// [dv/phy_basic_control_status_regs_tb.sv]
`timescale 1ns/100ps
module phy_basic_control_status_regs_tb
  import phy_regs_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        resetn, mdc, m_out, m_en, d_out, d_oe, rd_done, tx_en, col;
  logic        an_en_strap, duplex_strap, an_started, an_complete, an_full_duplex;
  logic        link_ok, far_end_fault, partner_rfault, mac_isolate, an_enable;
  logic        an_restart_req, full_duplex, pre, d;
  logic [1:0]  an_speed;
  logic [2:0]  speed_sel;
  logic [4:0]  phy_addr;
  logic [15:0] rd_word;
  logic [15:0] exp_q[$];
  int          err_count, samples_checked, cyc, n;
  wire         mdio_wire;

  // Pull-up when nobody drives
  assign mdio_wire = m_en ? m_out : (d_oe ? d_out : 1'b1);
  always #4 ref_clk = ~ref_clk;

  phy_basic_regs u_dut (
    .ref_clk(ref_clk), .resetn(resetn), .mdc(mdc), .mdio_in(mdio_wire),
    .mdio_out(d_out), .mdio_oe(d_oe), .phy_addr_strap(phy_addr),
    .an_en_strap(an_en_strap), .duplex_strap(duplex_strap), .tx_en(tx_en),
    .col(col), .an_started(an_started), .an_complete(an_complete),
    .an_speed(an_speed), .an_full_duplex(an_full_duplex), .link_ok(link_ok),
    .far_end_fault(far_end_fault), .partner_rfault(partner_rfault),
    .mac_isolate(mac_isolate), .an_enable(an_enable),
    .an_restart_req(an_restart_req), .speed_sel(speed_sel),
    .full_duplex(full_duplex));

  mgmt_ctrl_model u_mgmt (
    .ref_clk(ref_clk), .mdio_wire(mdio_wire), .mdc(mdc), .mdio_drv(m_out),
    .mdio_drv_en(m_en), .rd_done(rd_done), .rd_word(rd_word));

  task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic rd(input logic [4:0] ra, input logic [15:0] e);
    exp_q.push_back(e);
    u_mgmt.frame(pre, OP_READ, phy_addr, ra, 16'h0000);
    pre = 1'b0;
  endtask

  task automatic wr(input logic [15:0] v);
    u_mgmt.frame(pre, OP_WRITE, phy_addr, REG_CTRL_ADDR, v);
    pre = 1'b0;
  endtask

  task automatic tog(ref logic s);
    s = ~s;
    @(posedge ref_clk);
    #1 s = ~s;
  endtask

  task automatic wait_col(input logic v, input int lim);
    n = 0;
    while (col !== v && n < lim) begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask

  always @(posedge ref_clk) begin
    cyc++;
    if (rd_done === 1'b1) begin
      if (exp_q.size() > 0) begin
        check("read_data", exp_q.pop_front(), rd_word);
      end else begin
        err_count++;
        $display("Error read_data expected none seen %h", rd_word);
      end
    end
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    {tx_en, an_en_strap, an_started, an_complete, an_full_duplex} = 5'h00;
    {far_end_fault, partner_rfault, link_ok, pre} = 4'h3;
    void'($urandom(32'hcee1d459));
    an_speed = 2'($urandom_range(2, 0));
    phy_addr = 5'($urandom());
    duplex_strap = 1'($urandom());
    repeat (3) @(posedge ref_clk);
    #1 resetn = 1'b1;
    rd(REG_CTRL_ADDR, {7'h00, duplex_strap, 8'h40});
    rd(REG_STATUS_ADDR, 16'h7948);
    rd(REG_STATUS_ADDR, 16'h794c);
    $display("Test reset_values done");
    wr(16'hffff);
    check("restart_req", 16'h1, an_restart_req);
    check("isolate", 16'h1, mac_isolate);
    rd(REG_CTRL_ADDR, 16'h37c0);
    wr(16'h35c0);
    rd(REG_CTRL_ADDR, 16'h37c0);
    tog(an_started);
    rd(REG_CTRL_ADDR, 16'h35c0);
    wr(16'h0200);
    rd(REG_CTRL_ADDR, 16'h0000);
    check("restart_req", 16'h0, an_restart_req);
    check("an_enable", 16'h0, an_enable);
    $display("Test restart done");
    wr(16'h0080);
    tx_en = 1'b1;
    wait_col(1'b1, COL_ON_MAX_CYC);
    check("col_on", 16'h1, col);
    tx_en = 1'b0;
    wait_col(1'b0, COL_OFF_MAX_CYC);
    check("col_off", 16'h0, col);
    $display("Test collision done");
    for (int c = 0; c < 4; c++) begin
      d = 1'($urandom());
      wr({2'b00, c[0], 4'h0, d, 1'b0, c[1], 6'h00});
      check("speed_sel", (c == 3) ? 3'h0 : 3'(1 << (c[1] ? 2 : c[0])), speed_sel);
      check("full_duplex", d, full_duplex);
    end
    an_full_duplex = 1'($urandom());
    wr(16'h3140);
    check("an_speed_sel", 3'(1 << an_speed), speed_sel);
    check("an_duplex", an_full_duplex, full_duplex);
    check("an_enable", 16'h1, an_enable);
    $display("Test speed_duplex done");
    tog(far_end_fault);
    rd(REG_STATUS_ADDR, 16'h795c);
    rd(REG_STATUS_ADDR, 16'h794c);
    tog(partner_rfault);
    rd(REG_STATUS_ADDR, 16'h795c);
    an_complete = 1'b1;
    tog(link_ok);
    rd(REG_STATUS_ADDR, 16'h7968);
    rd(REG_STATUS_ADDR, 16'h796c);
    $display("Test status done");
    u_mgmt.frame(1'b0, OP_WRITE, ~phy_addr, REG_CTRL_ADDR, 16'h0400);
    u_mgmt.frame(1'b0, 2'b11, phy_addr, REG_CTRL_ADDR, 16'h0400);
    wr(16'h0400);
    pre = 1'b1;
    rd(REG_CTRL_ADDR, 16'h3140);
    check("isolate", 16'h0, mac_isolate);
    $display("Test refused_frames done");
    finish_test();
  end
endmodule
